// ### dass_area_select.sv
`timescale 1ns/1ps
module dass_area_select
  import dass_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mts_wr_en,
  input wire logic [2:0] mts_wr_data,
  output logic [2:0] mts_rd_data,
  input wire logic [3:0] area_cs_n,
  input wire dass_strobe_type strobe,
  output dass_cs_type pins,
  output logic [3:0] area_is_dram,
  output logic [3:0] area_is_sdram,
  output logic large_area_en,
  output logic sdram_mode_set
);

  logic [MTS_W-1:0] mts_q;
  logic [AREA_CNT-1:0] dram_d;
  logic [AREA_CNT-1:0] sdram_d;
  logic [AREA_CNT-1:0] dram_q;
  logic [AREA_CNT-1:0] sdram_q;
  logic large_q;
  logic mode_q;
  dass_cs_type pins_d;

  // both sdram codes drive the same strobes; only the mode flag differs
  function automatic logic is_cont_sdram(input logic [MTS_W-1:0] code);
    return (code == MTS_CONT_SDRAM) || (code == MTS_SDRAM_MODE);
  endfunction

  // any continuous code lifts the 2 MB per-area limit
  function automatic logic is_large(input logic [MTS_W-1:0] code);
    return (code == MTS_CONT_DRAM) || is_cont_sdram(code);
  endfunction

  // field register, software read and write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mts_q <= MTS_RESET;
    end else if (mts_wr_en) begin
      mts_q <= mts_wr_data;
    end
  end

  assign mts_rd_data = mts_q;

  // reserved codes fall back to normal space so pins stay sane
  always_comb begin
    dram_d = 4'h0;
    sdram_d = 4'h0;
    unique case (mts_q)
      MTS_NORMAL: dram_d = 4'h0;
      MTS_DRAM_A2: dram_d = 4'h1;
      MTS_DRAM_A23: dram_d = 4'h3;
      MTS_CONT_DRAM: dram_d = 4'h1;
      MTS_CONT_SDRAM, MTS_SDRAM_MODE: sdram_d = 4'h1;
      default: dram_d = 4'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dram_q <= 4'h0;
      sdram_q <= 4'h0;
      large_q <= 1'b0;
      mode_q <= 1'b0;
    end else begin
      dram_q <= dram_d;
      sdram_q <= sdram_d;
      large_q <= is_large(mts_q);
      mode_q <= (mts_q == MTS_SDRAM_MODE);
    end
  end

  // pins come from flops; strobes override chip selects in cont modes
  always_comb begin
    pins_d = dass_cs_type'(area_cs_n);
    if (mts_q == MTS_CONT_DRAM) begin
      pins_d.area2_select_pin_n = strobe.ras_n;
    end else if (is_cont_sdram(mts_q)) begin
      pins_d.area2_select_pin_n = strobe.ras_n;
      pins_d.area3_select_pin_n = strobe.cas_n;
      pins_d.area4_select_pin_n = strobe.we_n;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins <= dass_cs_type'(4'hf);
    end else begin
      pins <= pins_d;
    end
  end

  assign area_is_dram = dram_q;
  assign area_is_sdram = sdram_q;
  assign large_area_en = large_q;
  assign sdram_mode_set = mode_q;

  property p_decode_001;
    @(posedge clk) disable iff (rst)
      mts_q == MTS_DRAM_A2 |=> area_is_dram == 4'h1;
  endproperty
  a_decode_001: assert property (p_decode_001)
    else $error("001 must map area 2 to dram");

  property p_decode_010;
    @(posedge clk) disable iff (rst)
      mts_q == MTS_DRAM_A23 |=> area_is_dram == 4'h3;
  endproperty
  a_decode_010: assert property (p_decode_010)
    else $error("010 must map areas 2 and 3 to dram");

  property p_decode_000;
    @(posedge clk) disable iff (rst)
      mts_q == MTS_NORMAL |=> area_is_dram == 4'h0 && area_is_sdram == 4'h0;
  endproperty
  a_decode_000: assert property (p_decode_000)
    else $error("000 must leave all areas normal");

  property p_write_read;
    @(posedge clk) disable iff (rst)
      mts_wr_en |=> mts_rd_data == $past(mts_wr_data);
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("read does not return last write");

  property p_cont_ras;
    @(posedge clk) disable iff (rst)
      mts_q == MTS_CONT_DRAM |=>
        pins.area2_select_pin_n == $past(strobe.ras_n) && large_area_en;
  endproperty
  a_cont_ras: assert property (p_cont_ras)
    else $error("row strobe missing on area 2 pin");

  sequence s_sdram_cfg;
    mts_q == MTS_CONT_SDRAM;
  endsequence
  property p_sdram_pins;
    @(posedge clk) disable iff (rst)
      s_sdram_cfg |=> pins.area3_select_pin_n == $past(strobe.cas_n) &&
        pins.area4_select_pin_n == $past(strobe.we_n);
  endproperty
  a_sdram_pins: assert property (p_sdram_pins)
    else $error("sdram strobes missing on area 3/4 pins");

  property p_mode_set;
    @(posedge clk) disable iff (rst)
      mts_q == MTS_SDRAM_MODE |=> sdram_mode_set;
  endproperty
  a_mode_set: assert property (p_mode_set)
    else $error("mode-register setting not flagged");

  property p_mode_off;
    @(posedge clk) disable iff (rst)
      mts_q != MTS_SDRAM_MODE |=> !sdram_mode_set;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("mode-register setting flagged outside its code");

  // a write is taken at one edge, the flag follows one edge later
  sequence s_mode_write;
    mts_wr_en && mts_wr_data == MTS_SDRAM_MODE;
  endsequence
  property p_mode_write;
    @(posedge clk) disable iff (rst)
      s_mode_write |=> ##1 sdram_mode_set;
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode setting late after its write");

  property p_sdram_ras;
    @(posedge clk) disable iff (rst)
      is_cont_sdram(mts_q) |=>
        pins.area2_select_pin_n == $past(strobe.ras_n);
  endproperty
  a_sdram_ras: assert property (p_sdram_ras)
    else $error("row strobe missing on area 2 pin in sdram mode");

  property p_sdram_flags;
    @(posedge clk) disable iff (rst)
      is_cont_sdram(mts_q) |=>
        area_is_sdram == 4'h1 && area_is_dram == 4'h0 && large_area_en;
  endproperty
  a_sdram_flags: assert property (p_sdram_flags)
    else $error("sdram codes must mark area 2 as large sdram");

  property p_cont_dram_cs;
    @(posedge clk) disable iff (rst)
      mts_q == MTS_CONT_DRAM |=> area_is_dram[AREA2_POS] &&
        pins.area3_select_pin_n == $past(area_cs_n[1]) &&
        pins.area4_select_pin_n == $past(area_cs_n[2]);
  endproperty
  a_cont_dram_cs: assert property (p_cont_dram_cs)
    else $error("continuous dram must leave area 3/4 selects alone");

  // outside continuous codes the chip selects pass with one flop delay
  property p_normal_pins;
    @(posedge clk) disable iff (rst)
      !is_large(mts_q) |=> pins == $past(area_cs_n);
  endproperty
  a_normal_pins: assert property (p_normal_pins)
    else $error("chip selects not passed through in normal space");

  property p_cs5_pass;
    @(posedge clk) disable iff (rst)
      1'b1 |=> pins.cs5_n == $past(area_cs_n[3]);
  endproperty
  a_cs5_pass: assert property (p_cs5_pass)
    else $error("area 5 select must never carry a strobe");

  property p_large_off;
    @(posedge clk) disable iff (rst)
      !is_large(mts_q) |=> !large_area_en;
  endproperty
  a_large_off: assert property (p_large_off)
    else $error("large-area mode flagged outside continuous codes");

  sequence s_large_write;
    mts_wr_en && is_large(mts_wr_data);
  endsequence
  property p_large_write;
    @(posedge clk) disable iff (rst)
      s_large_write |=> ##1 large_area_en;
  endproperty
  a_large_write: assert property (p_large_write)
    else $error("large-area mode late after its write");

  property p_field_hold;
    @(posedge clk) disable iff (rst)
      !mts_wr_en |=> $stable(mts_rd_data);
  endproperty
  a_field_hold: assert property (p_field_hold)
    else $error("field changed without a write");

endmodule // dass_area_select

// ### dass_mem_model.sv
`timescale 1ns/1ps
module dass_mem_model
  import dass_pkg::*;
(
  input wire dass_cs_type pins,
  output logic [2:0] cmd_seen
);
  // memory samples row, column, write strobes on area 2..4 pins
  assign cmd_seen = {pins.area2_select_pin_n, pins.area3_select_pin_n,
    pins.area4_select_pin_n};
endmodule // dass_mem_model

// ### dass_pkg.sv
package dass_pkg;
  localparam int MTS_W = 3;
  localparam logic [2:0] MTS_RESET = 3'h0;
  localparam logic [2:0] MTS_NORMAL = 3'h0;
  localparam logic [2:0] MTS_DRAM_A2 = 3'h1;
  localparam logic [2:0] MTS_DRAM_A23 = 3'h2;
  localparam logic [2:0] MTS_CONT_DRAM = 3'h3;
  localparam logic [2:0] MTS_CONT_SDRAM = 3'h4;
  localparam logic [2:0] MTS_SDRAM_MODE = 3'h5;
  // area map bit positions: bit0 = area2 .. bit3 = area5
  localparam int AREA2_POS = 0;
  localparam int AREA_CNT = 4;
  // per-area memory kind
  typedef enum logic [1:0] {
    DASS_NORMAL = 2'h0,
    DASS_DRAM = 2'h1,
    DASS_SDRAM = 2'h2
  } dass_kind_type;
  // strobes from the dram sequencer, active low
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dass_strobe_type;
  // chip selects for areas 2..5, active low
  typedef struct packed {
    logic cs5_n;
    logic area4_select_pin_n;
    logic area3_select_pin_n;
    logic area2_select_pin_n;
  } dass_cs_type;
endpackage

// ### test_dram_area_space_select.sv
`timescale 1ns/1ps
module test_dram_area_space_select;
  import dass_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mts_wr_en = 1'b0;
  logic [2:0] mts_wr_data = 3'h0;
  logic [3:0] area_cs_n = 4'hf;
  dass_strobe_type stb = 3'h7;
  dass_cs_type pins;
  logic [2:0] mts_rd_data, cmd_seen;
  logic [3:0] area_is_dram, area_is_sdram;
  logic large_area_en, sdram_mode_set;
  int num_errors = 0;
  int samples_checked = 0;
  dass_area_select i_dut (.clk(clk), .rst(rst), .mts_wr_en(mts_wr_en),
    .mts_wr_data(mts_wr_data), .mts_rd_data(mts_rd_data),
    .area_cs_n(area_cs_n), .strobe(stb), .pins(pins),
    .area_is_dram(area_is_dram), .area_is_sdram(area_is_sdram),
    .large_area_en(large_area_en), .sdram_mode_set(sdram_mode_set));
  dass_mem_model i_mem (.pins(pins), .cmd_seen(cmd_seen));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [3:0] s,
    input logic [3:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // flags settle one edge after the write edge
  task automatic wr(input logic [2:0] v);
    mts_wr_en = 1'b1;
    mts_wr_data = v;
    @(negedge clk);
    mts_wr_en = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic test_decode();
    // code 7..0 nibbles of expected dram areas
    logic [31:0] dt = 32'h0000_1310;
    logic [7:0] lg = 8'h38;
    // reserved codes 110 and 111 are never written
    for (int i = 0; i < 6; i++) begin
      wr(i[2:0]);
      chk("rd", {1'b0, mts_rd_data}, i[3:0]);
      chk("dram", area_is_dram, dt[i*4+:4]);
      chk("large", {3'h0, large_area_en}, {3'h0, lg[i]});
      chk("mode", {3'h0, sdram_mode_set}, {3'h0, i == 5});
      chk("sdram", area_is_sdram, {3'h0, i >= 4});
    end
    $display("test_decode done");
  endtask
  task automatic test_pins();
    wr(3'h0);
    area_cs_n = 4'h6;
    repeat (2) @(negedge clk);
    chk("pins normal", pins, 4'h6);
    area_cs_n = 4'hf;
    stb = 3'h3;
    wr(3'h3);
    chk("pins dram", pins, 4'he);
    stb = 3'h2;
    wr(3'h4);
    chk("pins sdram", pins, 4'ha);
    chk("cmd", {1'b0, cmd_seen}, 4'h2);
    stb = 3'h5;
    wr(3'h5);
    chk("pins mode", pins, 4'hd);
    chk("cmd mode", {1'b0, cmd_seen}, 4'h5);
    $display("test_pins done");
  endtask
  task automatic test_reset();
    wr(3'h5);
    rst = 1'b1;
    @(negedge clk);
    chk("mid reset rd", {1'b0, mts_rd_data}, 4'h0);
    chk("mid reset pins", pins, 4'hf);
    chk("mid reset mode", {3'h0, sdram_mode_set}, 4'h0);
    rst = 1'b0;
    wr(3'h1);
    chk("after reset dram", area_is_dram, 4'h1);
    $display("test_reset done");
  endtask
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(negedge clk);
    chk("reset pins", pins, 4'hf);
    chk("reset rd", {1'b0, mts_rd_data}, 4'h0);
    rst = 1'b0;
    test_decode();
    test_pins();
    test_reset();
    give_verdict();
  end
endmodule // test_dram_area_space_select
